// *** verif/dual_mode_serial_control_port_monitor.sv ***
// pin level assertions for the serial control port
`timescale 1ns/1ps
module dual_mode_serial_control_port_monitor
(
  input wire logic                       clk_i,
  input wire logic                       rstn_i,
  input wire logic                       i2c_mode_i,
  input wire logic                       chip_select_i,
  input wire logic                       serial_data_oe_o,
  input wire logic                       serial_readback_out_o,
  input wire logic                       rf_output_disable_i,
  input wire logic                       rf_output_enable_o,
  input wire logic                       pll_locked_i,
  input wire logic                       pll_lock_indicator_o,
  input wire serial_port_pkg::lo_ctrl_t  lo_ctrl_o,
  input wire serial_port_pkg::latch_wr_t latch_wr_o
);
  logic [3:0] up_q;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rstn_i);
  // synchronisers need a few edges after any reset before outputs track the pins
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i) up_q <= 4'h0;
    else if (up_q != 4'hF) up_q <= up_q + 4'h1;
  end
  //////////////////////////////////////////////////////////////////////////////
  rf_follow_a: assert property (up_q > 4'h5 |-> rf_output_enable_o == !$past(rf_output_disable_i, 3))
    else $error("rf enable does not follow the disable pin");
  lock_follow_a: assert property (up_q > 4'h5 |-> pll_lock_indicator_o == $past(pll_locked_i, 3))
    else $error("lock indicator does not follow the loop");
  sda_quiet_a: assert property (!i2c_mode_i [*5] |-> !serial_data_oe_o)
    else $error("data pin pulled in four-wire mode");
  rb_quiet_a: assert property (i2c_mode_i [*5] |-> !serial_readback_out_o)
    else $error("readback active in i2c mode");
  wr_pulse_a: assert property (latch_wr_o.en |=> !latch_wr_o.en)
    else $error("latch write longer than one cycle");
  wr_range_a: assert property (latch_wr_o.en |-> latch_wr_o.addr < 5'h1F)
    else $error("write to a latch beyond the bank");
  wr_select_a: assert property (latch_wr_o.en && !i2c_mode_i |-> chip_select_i)
    else $error("four-wire write while select low");
  lo_load_a: assert property (latch_wr_o.en && latch_wr_o.addr == 5'h05 |->
    (lo_ctrl_o == latch_wr_o.data[3:0]) or (##1 lo_ctrl_o == $past(latch_wr_o.data[3:0])))
    else $error("lo control not loaded from its latch");
  lo_hold_a: assert property ($changed(lo_ctrl_o) && up_q > 4'h1 |->
    latch_wr_o.en || $past(latch_wr_o.en))
    else $error("lo control changed without a write");
endmodule : dual_mode_serial_control_port_monitor

// *** verif/serial_host_model.sv ***
// host master that bit-bangs the four-wire and i2c links
`timescale 1ns/1ps
module serial_host_model
(
  input  wire logic clk_i,
  input  wire logic sda_wire_i,
  input  wire logic readback_i,
  output logic      mode_o,
  output logic      cs_o,
  output logic      sclk_o,
  output logic      data_o
);
  initial
  begin
    mode_o = 1'b0;
    cs_o   = 1'b1;
    sclk_o = 1'b0;
    data_o = 1'b0;
  end
  task wt(input int n);
    repeat (n) @(posedge clk_i);
  endtask : wt
  task set_i2c(input logic m, input logic cs);
    wt(1);
    mode_o <= m;
    cs_o   <= cs;
    wt(8);
  endtask : set_i2c
  //////////////////////////////////////////////////////////////////////////////
  // host drives the clock and whole 16-bit frames, msb first
  task spi_xfer(input logic [15:0] w, output logic [7:0] rb);
    wt(1);
    cs_o <= 1'b0;
    for (int i = 15; i >= 0; i--)
    begin
      wt(1);
      sclk_o <= 1'b0;
      data_o <= w[i];
      // sample a clock before the rise: the readback bit turns over right at it
      wt(3);
      if (i < 8) rb[i] = readback_i;
      wt(1);
      sclk_o <= 1'b1;
      wt(3);
    end
    wt(1);
    sclk_o <= 1'b0;
    data_o <= ~w[0];
    wt(4);
    cs_o <= 1'b1;
    wt(12);
  endtask : spi_xfer
  task i2c_start;
    wt(2);
    data_o <= 1'b1;
    wt(2);
    sclk_o <= 1'b1;
    wt(4);
    data_o <= 1'b0;
    wt(4);
    sclk_o <= 1'b0;
  endtask : i2c_start
  task i2c_stop;
    wt(2);
    data_o <= 1'b0;
    wt(2);
    sclk_o <= 1'b1;
    wt(4);
    data_o <= 1'b1;
    wt(8);
  endtask : i2c_stop
  // ninth clock carries the master bit mack, the slave answer is read back
  task i2c_byte(input logic [7:0] tx, input logic mack, output logic [7:0] rx,
                output logic ack);
    for (int i = 8; i >= 0; i--)
    begin
      wt(2);
      data_o <= (i > 0) ? tx[i-1] : mack;
      wt(2);
      sclk_o <= 1'b1;
      wt(2);
      if (i > 0) rx[i-1] = sda_wire_i;
      else ack = sda_wire_i;
      wt(2);
      sclk_o <= 1'b0;
    end
  endtask : i2c_byte
endmodule : serial_host_model

// *** verif/tb_dual_mode_serial_control_port.sv ***
// self-checking bench for the dual mode serial control port
`timescale 1ns/1ps
module tb_dual_mode_serial_control_port;
  logic                      clk_i, rstn_i, rf_dis, locked;
  logic                      mode, cs, sclk, hdata, serial_readback_out, oe, rb_pin, rf_en, lock_ind;
  logic                      sda_wire, din;
  logic [7:0]                rb, rb2;
  logic [2:0]                ak;
  serial_port_pkg::lo_ctrl_t lo;
  serial_port_pkg::latch_wr_t wr, last_wr;
  int                        n_fail, num_checks, n_wr, n;
  logic [7:0]                lo_set [6] = '{8'h04, 8'h05, 8'h06, 8'h07, 8'h03, 8'h0B};
  // open drain with pull-up: device can only pull low
  assign sda_wire = (oe ? serial_readback_out : 1'b1) & hdata;
  assign din = mode ? sda_wire : hdata;
  dual_mode_serial_control_port u_dut (.clk_i(clk_i), .rstn_i(rstn_i), .i2c_mode_i(mode),
    .chip_select_i(cs), .serial_clock_i(sclk), .serial_data_i(din), .serial_data_o(serial_readback_out),
    .serial_data_oe_o(oe), .serial_readback_out_o(rb_pin), .rf_output_disable_i(rf_dis),
    .rf_output_enable_o(rf_en), .pll_locked_i(locked), .pll_lock_indicator_o(lock_ind),
    .lo_ctrl_o(lo), .latch_wr_o(wr));
  serial_host_model u_host (.clk_i(clk_i), .sda_wire_i(sda_wire), .readback_i(rb_pin),
    .mode_o(mode), .cs_o(cs), .sclk_o(sclk), .data_o(hdata));
  initial
  begin
    clk_i = 1'b0;
    forever #10 clk_i = ~clk_i;
  end
  always @(posedge clk_i)
  begin
    if (wr.en === 1'b1)
    begin
      n_wr++;
      last_wr <= wr;
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  task check(input logic [15:0] seen, input logic [15:0] exp);
    num_checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task report_and_stop;
    if (n_fail == 0 && num_checks > 0) $display("All checks passed");
    else $display("Checks failed");
    $finish;
  endtask : report_and_stop
  task spi_wr(input logic [4:0] idx, input logic [7:0] d);
    u_host.spi_xfer({3'h0, idx, d}, rb);
  endtask : spi_wr
  task spi_rd(input logic [4:0] idx);
    u_host.spi_xfer({3'h4, idx, 8'h00}, rb);
  endtask : spi_rd
  task i2c_wr(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic [7:0] x;
    u_host.i2c_start();
    u_host.i2c_byte({a, 1'b0}, 1'b1, x, ak[2]);
    u_host.i2c_byte(p, 1'b1, x, ak[1]);
    u_host.i2c_byte(d, 1'b1, x, ak[0]);
    u_host.i2c_stop();
  endtask : i2c_wr
  task i2c_rd(input logic [6:0] a, input logic [7:0] p);
    logic [7:0] x;
    logic       k;
    u_host.i2c_start();
    u_host.i2c_byte({a, 1'b0}, 1'b1, x, k);
    u_host.i2c_byte(p, 1'b1, x, k);
    u_host.i2c_start();
    u_host.i2c_byte({a, 1'b1}, 1'b1, x, k);
    u_host.i2c_byte(8'hFF, 1'b0, rb, k);
    u_host.i2c_byte(8'hFF, 1'b1, rb2, k);
    u_host.i2c_stop();
  endtask : i2c_rd
  initial
  begin
    rstn_i = 1'b0;
    rf_dis = 1'b0;
    locked = 1'b0;
    n_fail = 0;
    num_checks = 0;
    n_wr = 0;
    repeat (8) @(posedge clk_i);
    check(lo, 4'h0);
    check(wr.en, 1'b0);
    rstn_i <= 1'b1;
    u_host.wt(6);
    foreach (lo_set[k])
    begin
      spi_wr(5'h05, lo_set[k]);
      check(lo, lo_set[k][3:0]);
      check(last_wr, {1'b1, 5'h05, lo_set[k]});
    end
    spi_rd(5'h05);
    check(rb, 8'h0B);
    spi_wr(5'h1E, 8'hA5);
    spi_rd(5'h1E);
    check(rb, 8'hA5);
    n = n_wr;
    spi_wr(5'h1F, 8'h3C);
    check(16'(n_wr), 16'(n));
    spi_rd(5'h1F);
    check(rb, 8'h00);
    rf_dis <= 1'b1;
    locked <= 1'b1;
    u_host.wt(5);
    check({rf_en, lock_ind}, 2'h1);
    rf_dis <= 1'b0;
    locked <= 1'b0;
    u_host.wt(5);
    check({rf_en, lock_ind}, 2'h2);
    u_host.set_i2c(1'b1, 1'b1);
    i2c_wr(7'h60, 8'h05, 8'h06);
    check(ak, 3'h0);
    check(lo, 4'h6);
    i2c_wr(7'h40, 8'h05, 8'h01);
    check(ak, 3'h7);
    check(lo, 4'h6);
    u_host.set_i2c(1'b1, 1'b0);
    i2c_wr(7'h40, 8'h05, 8'h0A);
    check(ak, 3'h0);
    check(lo, 4'hA);
    i2c_wr(7'h40, 8'h06, 8'h5A);
    check(ak, 3'h0);
    i2c_rd(7'h40, 8'h05);
    check(rb, 8'h0A);
    check(rb2, 8'h5A);
    u_host.set_i2c(1'b0, 1'b1);
    spi_rd(5'h05);
    check(rb, 8'h0A);
    report_and_stop();
  end
  initial
  begin
    #200us;
    n_fail++;
    report_and_stop();
  end
endmodule : tb_dual_mode_serial_control_port
bind dual_mode_serial_control_port dual_mode_serial_control_port_monitor u_mon (
  .clk_i(clk_i), .rstn_i(rstn_i), .i2c_mode_i(i2c_mode_i), .chip_select_i(chip_select_i),
  .serial_data_oe_o(serial_data_oe_o), .serial_readback_out_o(serial_readback_out_o),
  .rf_output_disable_i(rf_output_disable_i), .rf_output_enable_o(rf_output_enable_o),
  .pll_locked_i(pll_locked_i), .pll_lock_indicator_o(pll_lock_indicator_o),
  .lo_ctrl_o(lo_ctrl_o), .latch_wr_o(latch_wr_o));

// *** verilog/dual_mode_serial_control_port.sv ***
// four-wire and i2c control port with latch bank and pin level status
`timescale 1ns/1ps
module dual_mode_serial_control_port
(
  input  wire logic                  clk_i,
  input  wire logic                  rstn_i,
  input  wire logic                  i2c_mode_i,
  input  wire logic                  chip_select_i,
  input  wire logic                  serial_clock_i,
  input  wire logic                  serial_data_i,
  output logic                       serial_data_o,
  output logic                       serial_data_oe_o,
  output logic                       serial_readback_out_o,
  input  wire logic                  rf_output_disable_i,
  output logic                       rf_output_enable_o,
  input  wire logic                  pll_locked_i,
  output logic                       pll_lock_indicator_o,
  output serial_port_pkg::lo_ctrl_t  lo_ctrl_o,
  output serial_port_pkg::latch_wr_t latch_wr_o
);

  //////////////////////////////////////////////////////////////////////////////
  // synchronisers: every pin crosses two flops; the third stage is for edges

  logic [serial_port_pkg::SY_BITS-1:0] sync1_q;
  logic [serial_port_pkg::SY_BITS-1:0] sync2_q;
  logic [serial_port_pkg::SY_BITS-1:0] sync3_q;

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      sync1_q <= '0;
      sync2_q <= '0;
      sync3_q <= '0;
    end
    else
    begin
      sync1_q <= {pll_locked_i, rf_output_disable_i, serial_data_i,
                  serial_clock_i, chip_select_i, i2c_mode_i};
      sync2_q <= sync1_q;
      sync3_q <= sync2_q;
    end
  end

  logic i2c_mode;
  logic cs;
  logic clk_rise;
  logic clk_fall;
  logic dat;
  logic cs_rise;
  logic start_cond;
  logic stop_cond;

  // host supplies the serial clock; its edges are found on the system clock
  assign i2c_mode   = sync2_q[serial_port_pkg::SY_MODE];
  assign cs         = sync2_q[serial_port_pkg::SY_CS];
  assign dat        = sync2_q[serial_port_pkg::SY_DATA];
  assign clk_rise   = sync2_q[serial_port_pkg::SY_CLK] & ~sync3_q[serial_port_pkg::SY_CLK];
  assign clk_fall   = ~sync2_q[serial_port_pkg::SY_CLK] & sync3_q[serial_port_pkg::SY_CLK];
  assign cs_rise    = cs & ~sync3_q[serial_port_pkg::SY_CS];
  // start and stop are data edges while the clock stays high
  assign start_cond = i2c_mode & sync2_q[serial_port_pkg::SY_CLK]
                      & sync3_q[serial_port_pkg::SY_CLK] & ~dat
                      & sync3_q[serial_port_pkg::SY_DATA];
  assign stop_cond  = i2c_mode & sync2_q[serial_port_pkg::SY_CLK]
                      & sync3_q[serial_port_pkg::SY_CLK] & dat
                      & ~sync3_q[serial_port_pkg::SY_DATA];

  //////////////////////////////////////////////////////////////////////////////
  // latch bank

  logic [serial_port_pkg::WORD_BITS-1:0] latch_q [serial_port_pkg::NUM_LATCHES];
  serial_port_pkg::latch_wr_t            spi_wr;
  serial_port_pkg::latch_wr_t            i2c_wr;
  serial_port_pkg::latch_wr_t            wr;

  // the two ports never run together, mode picks which one may write
  assign wr = i2c_mode ? i2c_wr : spi_wr;

  generate
    for (genvar gi = 0; gi < serial_port_pkg::NUM_LATCHES; gi++)
    begin : g_latch
      always_ff @(posedge clk_i)
      begin
        if (!rstn_i)
          latch_q[gi] <= serial_port_pkg::LATCH_RESET;
        else if (wr.en && wr.addr == 5'(gi))
          latch_q[gi] <= wr.data;
      end
    end
  endgenerate

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      latch_wr_o <= '0;
    else
      latch_wr_o <= wr;
  end

  //////////////////////////////////////////////////////////////////////////////
  // four-wire port: command byte, then data byte, committed on select rising

  logic [serial_port_pkg::WORD_BITS-1:0] spi_sh_q;
  logic [serial_port_pkg::CNT_BITS-1:0]  spi_cnt_q;
  logic [serial_port_pkg::ADDR_BITS-1:0] spi_addr_q;
  logic                                  spi_rd_q;
  logic                                  spi_cmd_done_q;
  logic                                  spi_have_data_q;
  logic [serial_port_pkg::WORD_BITS-1:0] spi_data_q;
  logic [serial_port_pkg::WORD_BITS-1:0] spi_tx_q;
  logic [serial_port_pkg::WORD_BITS-1:0] spi_byte;

  assign spi_byte = {spi_sh_q[6:0], dat};

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || i2c_mode || cs)
    begin
      spi_sh_q        <= '0;
      spi_cnt_q       <= '0;
      spi_addr_q      <= '0;
      spi_rd_q        <= 1'b0;
      spi_cmd_done_q  <= 1'b0;
      spi_have_data_q <= 1'b0;
      spi_data_q      <= '0;
    end
    else if (clk_rise)
    begin
      spi_sh_q <= spi_byte;
      if (spi_cnt_q == serial_port_pkg::WORD_CNT - 4'h1)
      begin
        spi_cnt_q <= '0;
        if (!spi_cmd_done_q)
        begin
          spi_cmd_done_q <= 1'b1;
          spi_addr_q     <= spi_byte[serial_port_pkg::ADDR_BITS-1:0];
          spi_rd_q       <= spi_byte[serial_port_pkg::CMD_READ_BIT];
        end
        else
        begin
          spi_have_data_q <= 1'b1;
          spi_data_q      <= spi_byte;
        end
      end
      else
        spi_cnt_q <= spi_cnt_q + 4'h1;
    end
  end

  // the write lands only when a full data byte was seen and the index exists
  always_comb
  begin
    spi_wr.en   = cs_rise & ~i2c_mode & spi_have_data_q & ~spi_rd_q
                  & (spi_addr_q < 5'(serial_port_pkg::NUM_LATCHES));
    spi_wr.addr = spi_addr_q;
    spi_wr.data = spi_data_q;
  end

  // readback word loads after the command byte and shifts on falling clock
  logic spi_load_tx;
  assign spi_load_tx = ~cs & ~i2c_mode & clk_rise & ~spi_cmd_done_q
                       & (spi_cnt_q == serial_port_pkg::WORD_CNT - 4'h1);

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || cs || i2c_mode)
      spi_tx_q <= '0;
    else if (spi_load_tx)
      spi_tx_q <= (spi_byte[serial_port_pkg::ADDR_BITS-1:0]
                   < 5'(serial_port_pkg::NUM_LATCHES))
                  ? latch_q[spi_byte[serial_port_pkg::ADDR_BITS-1:0]] : '0;
    else if (clk_fall && spi_cmd_done_q && spi_rd_q)
      spi_tx_q <= {spi_tx_q[6:0], 1'b0};
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      serial_readback_out_o <= 1'b0;
    else
      serial_readback_out_o <= spi_cmd_done_q & spi_rd_q & spi_tx_q[7];
  end

  //////////////////////////////////////////////////////////////////////////////
  // i2c port: address, latch pointer, then data bytes with auto increment

  serial_port_pkg::i2c_state_t           i2c_state_q;
  logic [serial_port_pkg::WORD_BITS-1:0] i2c_sh_q;
  logic [serial_port_pkg::CNT_BITS-1:0]  i2c_cnt_q;
  logic [1:0]                            i2c_byte_q;
  logic                                  i2c_rw_q;
  logic [serial_port_pkg::ADDR_BITS-1:0] i2c_ptr_q;
  logic [serial_port_pkg::WORD_BITS-1:0] i2c_tx_q;
  logic [6:0]                            my_addr;
  logic                                  i2c_byte_end;

  assign my_addr      = cs ? serial_port_pkg::I2C_ADDR_CS_HI
                           : serial_port_pkg::I2C_ADDR_CS_LO;
  assign i2c_byte_end = clk_fall && i2c_cnt_q == serial_port_pkg::WORD_CNT;

  always_comb
  begin
    i2c_wr.en   = (i2c_state_q == serial_port_pkg::I2C_RX) & i2c_byte_end
                  & (i2c_byte_q == 2'h2)
                  & (i2c_ptr_q < 5'(serial_port_pkg::NUM_LATCHES));
    i2c_wr.addr = i2c_ptr_q;
    i2c_wr.data = i2c_sh_q;
  end

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i || !i2c_mode || stop_cond)
    begin
      i2c_state_q      <= serial_port_pkg::I2C_IDLE;
      i2c_sh_q         <= '0;
      i2c_cnt_q        <= '0;
      i2c_byte_q       <= '0;
      i2c_rw_q         <= 1'b0;
      i2c_ptr_q        <= '0;
      i2c_tx_q         <= '0;
      serial_data_oe_o <= 1'b0;
    end
    else if (start_cond)
    begin
      i2c_state_q      <= serial_port_pkg::I2C_RX;
      i2c_cnt_q        <= '0;
      i2c_byte_q       <= '0;
      serial_data_oe_o <= 1'b0;
    end
    else
    begin
      unique case (i2c_state_q)
        serial_port_pkg::I2C_IDLE: ;
        serial_port_pkg::I2C_RX:
        begin
          if (clk_rise && i2c_cnt_q != serial_port_pkg::WORD_CNT)
          begin
            i2c_sh_q  <= {i2c_sh_q[6:0], dat};
            i2c_cnt_q <= i2c_cnt_q + 4'h1;
          end
          else if (i2c_byte_end)
          begin
            i2c_cnt_q <= '0;
            if (i2c_byte_q == 2'h0 && i2c_sh_q[7:1] != my_addr)
              i2c_state_q <= serial_port_pkg::I2C_IDLE;
            else
            begin
              i2c_state_q      <= serial_port_pkg::I2C_ACK;
              serial_data_oe_o <= 1'b1;
              if (i2c_byte_q == 2'h0)
                i2c_rw_q <= i2c_sh_q[0];
              else if (i2c_byte_q == 2'h1)
                i2c_ptr_q <= i2c_sh_q[serial_port_pkg::ADDR_BITS-1:0];
              else
                i2c_ptr_q <= i2c_ptr_q + 5'h01;
              if (i2c_byte_q != 2'h2)
                i2c_byte_q <= i2c_byte_q + 2'h1;
            end
          end
        end
        serial_port_pkg::I2C_ACK:
        begin
          if (clk_fall)
          begin
            if (i2c_rw_q)
            begin
              // reads return the latch under the pointer, data pin drives low bits
              i2c_tx_q <= (i2c_ptr_q < 5'(serial_port_pkg::NUM_LATCHES))
                          ? latch_q[i2c_ptr_q] : '0;
              serial_data_oe_o <= (i2c_ptr_q < 5'(serial_port_pkg::NUM_LATCHES))
                                  ? ~latch_q[i2c_ptr_q][7] : 1'b1;
              i2c_ptr_q   <= i2c_ptr_q + 5'h01;
              i2c_cnt_q   <= 4'h1;
              i2c_state_q <= serial_port_pkg::I2C_TX;
            end
            else
            begin
              serial_data_oe_o <= 1'b0;
              i2c_state_q      <= serial_port_pkg::I2C_RX;
            end
          end
        end
        serial_port_pkg::I2C_TX:
        begin
          if (clk_fall)
          begin
            if (i2c_cnt_q == serial_port_pkg::WORD_CNT)
            begin
              serial_data_oe_o <= 1'b0;
              i2c_state_q      <= serial_port_pkg::I2C_RACK;
            end
            else
            begin
              serial_data_oe_o <= ~i2c_tx_q[6];
              i2c_tx_q         <= {i2c_tx_q[6:0], 1'b0};
              i2c_cnt_q        <= i2c_cnt_q + 4'h1;
            end
          end
        end
        serial_port_pkg::I2C_RACK:
        begin
          // a master ack hands over to the load step so the next byte starts at
          // the ninth fall, not one clock late; a nack releases the bus until the next start
          if (clk_rise)
            i2c_state_q <= dat ? serial_port_pkg::I2C_IDLE : serial_port_pkg::I2C_ACK;
        end
      endcase
    end
  end

  // open drain: only ever pulls low
  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
      serial_data_o <= 1'b0;
    else
      serial_data_o <= 1'b0;
  end

  //////////////////////////////////////////////////////////////////////////////
  // pin level status and lo control outputs

  always_ff @(posedge clk_i)
  begin
    if (!rstn_i)
    begin
      rf_output_enable_o   <= 1'b0;
      pll_lock_indicator_o <= 1'b0;
      lo_ctrl_o            <= '0;
    end
    else
    begin
      rf_output_enable_o   <= ~sync2_q[serial_port_pkg::SY_DIS];
      pll_lock_indicator_o <= sync2_q[serial_port_pkg::SY_LOCK];
      lo_ctrl_o.lo_monitor_level  <= latch_q[serial_port_pkg::LO_CTRL_LATCH]
                                     [serial_port_pkg::LO_LEVEL_LSB +: 2];
      lo_ctrl_o.lo_monitor_en     <= latch_q[serial_port_pkg::LO_CTRL_LATCH]
                                     [serial_port_pkg::LO_MON_EN_BIT];
      lo_ctrl_o.ext_double_lo_sel <= latch_q[serial_port_pkg::LO_CTRL_LATCH]
                                     [serial_port_pkg::EXT_LO_SEL_BIT];
    end
  end

endmodule : dual_mode_serial_control_port

// *** verilog/serial_port_pkg.sv ***
// constants and carrier types for the dual mode serial control port
// Notes on behaviour
// - chip select rising loads shift word into latch
// - i2c address 0x60 with select high, 0x40 low
// - four-wire data moves in 8-bit words
// - i2c data pin receives and returns data
// - readback shifts out on dedicated data output
// - disable input high turns rf output off
// - lock indicator high when locked, low otherwise
// - lo monitor: four levels or switched off
// - external double lo selectable by programming
package serial_port_pkg;

  localparam int          NUM_LATCHES   = 31;
  localparam int          WORD_BITS     = 8;
  localparam int          ADDR_BITS     = 5;
  localparam int          CNT_BITS      = 4;
  localparam logic [3:0]  WORD_CNT      = 4'h8;
  localparam logic [7:0]  LATCH_RESET   = 8'h00;
  // four-wire command byte: bit 7 asks for readback, low bits pick the latch
  localparam int          CMD_READ_BIT  = 7;
  // i2c slave addresses, seven bits, picked by the chip select level
  localparam logic [6:0]  I2C_ADDR_CS_HI = 7'h60;
  localparam logic [6:0]  I2C_ADDR_CS_LO = 7'h40;
  // latch that steers the lo monitor and the lo source
  localparam logic [4:0]  LO_CTRL_LATCH  = 5'h05;
  localparam int          LO_LEVEL_LSB   = 0;
  localparam int          LO_MON_EN_BIT  = 2;
  localparam int          EXT_LO_SEL_BIT = 3;
  // positions in the synchroniser vector
  localparam int          SY_MODE = 0;
  localparam int          SY_CS   = 1;
  localparam int          SY_CLK  = 2;
  localparam int          SY_DATA = 3;
  localparam int          SY_DIS  = 4;
  localparam int          SY_LOCK = 5;
  localparam int          SY_BITS = 6;

  typedef struct packed {
    logic                 en;
    logic [ADDR_BITS-1:0] addr;
    logic [WORD_BITS-1:0] data;
  } latch_wr_t;

  typedef struct packed {
    logic       ext_double_lo_sel;
    logic       lo_monitor_en;
    logic [1:0] lo_monitor_level;
  } lo_ctrl_t;

  typedef enum logic [2:0] {
    I2C_IDLE,
    I2C_RX,
    I2C_ACK,
    I2C_TX,
    I2C_RACK
  } i2c_state_t;

endpackage : serial_port_pkg
